// ==== logic/pwm_stage_regs.svh ====
/*
 * Register offsets, field positions and reset values of the
 * motor PWM output stage.
 * Assumes a 4-bit register address and 8-bit register data.
 */
`ifndef PWM_STAGE_REGS_SVH
`define PWM_STAGE_REGS_SVH

`define ADDR_CONFIG      4'h0
`define ADDR_DEADTIME    4'h1
`define ADDR_DISABLE_BANK_MAPPING      4'h2
`define ADDR_OVERRIDE    4'h3
`define ADDR_CONTROL     4'h4
`define ADDR_FAULT_CTRL  4'h5
`define ADDR_FAULT_STAT  4'h6
`define ADDR_OUT_STATUS  4'h7

`define CFG_CHANNEL_INDEPENDENCE_OPTION        0
`define CFG_TOP_NEG      1
`define CFG_BOT_NEG      2

`define OVR_ENABLE       7

`define CTL_ENABLE       0
`define CTL_DIS_X        1
`define CTL_DIS_Y        2

`define FCT_FMODE1       0
`define FCT_FMODE4       1
`define FCT_FINT1        2
`define FCT_FINT4        3

`define FST_FLAG1        0
`define FST_PIN1         1
`define FST_FLAG4        2
`define FST_PIN4         3

`define OST_OFF_X        6
`define OST_OFF_Y        7

`define DEADTIME_RESET   8'hff
`define DISABLE_BANK_MAPPING_RESET     8'hff

`endif

// ==== logic/pwm_stage_pkg.sv ====
/*
 * Types of the motor PWM output stage: register port request and the
 * complete state of the stage.
 * Assumes the offsets in pwm_stage_regs.svh.
 */
package pwm_stage_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;

    typedef struct packed {
        logic            cfg_written;
        logic            channel_independence_option;
        logic            top_neg;
        logic            bot_neg;
        logic            dt_written;
        logic [7:0]      deadtime;
        logic            map_written;
        logic [7:0]      disable_bank_mapping;
        logic [7:0]      override;
        logic            enable;
        logic            dis_x;
        logic            dis_y;
        logic            fmode1;
        logic            fmode4;
        logic            fint1;
        logic            fint4;
        logic [1:0]      sync1;
        logic [1:0]      sync2;
        logic [1:0]      f_prev;
        logic            flag1;
        logic            flag4;
        logic            src_override;
        logic            off_x;
        logic            off_y;
        logic [2:0]      dt_in;
        logic [2:0][7:0] dt_cnt;
        logic [5:0]      pin;
        logic [5:0]      oe_n;
        logic [7:0]      rdata;
        logic [1:0]      irq;
    } stage_state_type;

endpackage

// ==== logic/motor_pwm_output_stage.sv ====
/*
 * Output stage of a six-channel motor PWM: channel pairing, dead-time
 * insertion, polarity, software override of the pins and two disable
 * banks fed by fault pins and software disable bits.
 * Assumes a generator on ref_clk that supplies six raw outputs and a
 * one-cycle pulse at the start of each counting period; fault pins are
 * asynchronous and are synchronised here.
 */
// Notes on behaviour
// - Six independent channels or three complementary pairs, set once.
// - Complementary: one generator output drives a pair; else one each.
// - Dead-time is an 8-bit count of clock cycles, written once.
// - Dead-time counts clock cycles, never prescaled generator ticks.
// - Complementary: top signal feeds dead-time logic, bottom derived.
// - Any dead-time input change holds both pair outputs inactive.
// - With override on, odd override bits feed the dead-time logic.
// - Top polarity sets outputs 1,3,5; bottom sets 2,4,6.
// - Both polarity options sit in a write-once configuration register.
// - Override on: independent outputs follow their override bits.
// - Complementary override: even bit 1 complements top, 0 inactive.
// - Override keeps polarity, never both active, keeps dead-time.
// - Odd override bit toggles insert dead-time; even bit changes not.
// - Override leaves generator and current sensing running.
// - Override drives the pins even with the module disabled.
// - Clearing override returns generator at next period start; code drops override at once with the module disabled.
// - Fault input high or software disable forces mapped outputs off.
// - Bank X: fault input 1 plus bank X software disable.
// - Bank Y: fault input 4 plus bank Y disable, via write-once map.
// - Mapping all ones: any disable forces all six outputs inactive.
// - Manual mode: fault 4 clears only with input low; fault 1 always.
// - Each fault input raises its own interrupt request.
`include "pwm_stage_regs.svh"

module motor_pwm_output_stage
    import pwm_stage_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire bus_req_type bus_req,
    output logic [7:0]       rdata,
    input  wire logic [5:0]  gen_out,
    input  wire logic        cycle_start,
    input  wire logic        fault1_pin,
    input  wire logic        fault4_pin,
    output logic [5:0]       pwm_pin,
    output logic [5:0]       pwm_oe_n,
    output logic [1:0]       fault_irq
);

    stage_state_type s;
    stage_state_type next_s;

    // Pin level for an active or inactive channel
    function automatic logic drive_level(input logic act, input logic neg);
        drive_level = act ^ neg;
    endfunction

    // Bank Y mapping bit serving output i
    function automatic logic map_y(input logic [7:0] map, input int i);
        map_y = (i < 3) ? map[6] : map[7];
    endfunction

    logic [5:0] neg_mask;
    logic [5:0] pin_act;

    assign neg_mask = {3{s.bot_neg, s.top_neg}};
    assign pin_act  = s.pin ^ neg_mask;

    always_comb begin
        logic       wr_cfg;
        logic       ack1;
        logic       ack4;
        logic [1:0] rise;
        logic       cond1;
        logic       cond4;
        logic       release_ok;
        logic [5:0] gen;
        logic [5:0] act;
        logic       in_now;
        logic       changed;
        logic       hold;
        logic       drive;
        wr_cfg     = 1'b0;
        ack1       = 1'b0;
        ack4       = 1'b0;
        rise       = 2'b00;
        cond1      = 1'b0;
        cond4      = 1'b0;
        release_ok = 1'b0;
        gen        = 6'h00;
        act        = 6'h00;
        in_now     = 1'b0;
        changed    = 1'b0;
        hold       = 1'b0;
        drive      = 1'b0;
        next_s     = s;

        // Fault pin synchronisers and edge history
        next_s.sync1  = {fault4_pin, fault1_pin};
        next_s.sync2  = s.sync1;
        next_s.f_prev = s.sync2;
        rise          = s.sync2 & ~s.f_prev;

        if (bus_req.wr) begin
            case (bus_req.addr)
                `ADDR_CONFIG: begin
                    if (!s.cfg_written) begin
                        next_s.cfg_written = 1'b1;
                        next_s.channel_independence_option   = bus_req.wdata[`CFG_CHANNEL_INDEPENDENCE_OPTION];
                        next_s.top_neg = bus_req.wdata[`CFG_TOP_NEG];
                        next_s.bot_neg = bus_req.wdata[`CFG_BOT_NEG];
                    end
                    wr_cfg = 1'b1;
                end
                `ADDR_DEADTIME: begin
                    if (!s.dt_written) begin
                        next_s.dt_written = 1'b1;
                        next_s.deadtime   = bus_req.wdata;
                    end
                end
                `ADDR_DISABLE_BANK_MAPPING: begin
                    if (!s.map_written) begin
                        next_s.map_written = 1'b1;
                        next_s.disable_bank_mapping      = bus_req.wdata;
                    end
                end
                `ADDR_OVERRIDE: begin
                    next_s.override = bus_req.wdata;
                end
                `ADDR_CONTROL: begin
                    next_s.enable = bus_req.wdata[`CTL_ENABLE];
                    next_s.dis_x  = bus_req.wdata[`CTL_DIS_X];
                    next_s.dis_y  = bus_req.wdata[`CTL_DIS_Y];
                end
                `ADDR_FAULT_CTRL: begin
                    next_s.fmode1 = bus_req.wdata[`FCT_FMODE1];
                    next_s.fmode4 = bus_req.wdata[`FCT_FMODE4];
                    next_s.fint1  = bus_req.wdata[`FCT_FINT1];
                    next_s.fint4  = bus_req.wdata[`FCT_FINT4];
                end
                `ADDR_FAULT_STAT: begin
                    ack1 = bus_req.wdata[`FST_FLAG1];
                    ack4 = bus_req.wdata[`FST_FLAG4];
                end
                default: begin
                    wr_cfg = 1'b0;
                end
            endcase
        end

        // Event flags: a new edge wins over an acknowledge
        next_s.flag1 = (s.flag1 & ~ack1) | rise[0];
        next_s.flag4 = (s.flag4 & ~ack4) | rise[1];
        // One request line per fault input
        next_s.irq = {next_s.flag4 & next_s.fint4,
                      next_s.flag1 & next_s.fint1};

        // Manual fault 1 follows its flag, fault 4 also its pin
        cond1 = s.fmode1 ? s.sync2[0] : s.flag1;
        cond4 = s.fmode4 ? s.sync2[1] : (s.flag4 | s.sync2[1]);

        // Disable immediately, release at period start or while override holds the pins
        release_ok   = cycle_start | s.src_override;
        next_s.off_x = cond1 | s.dis_x | (s.off_x & ~release_ok);
        next_s.off_y = cond4 | s.dis_y | (s.off_y & ~release_ok);

        // Generator regains the pins at a period start; with the module disabled override drops at once
        next_s.src_override = s.override[`OVR_ENABLE] |
            (s.src_override & ~cycle_start & s.enable);

        // Generator is only gated at the pins, never stopped here
        gen = s.enable ? gen_out : 6'h00;

        for (int p = 0; p < 3; p++) begin
            if (s.channel_independence_option) begin
                act[2*p]   = s.src_override ? s.override[2*p] : gen[2*p];
                // Each output uses its own generator channel
                act[2*p+1] = s.src_override ? s.override[2*p+1]
                                            : gen[2*p+1];
                next_s.dt_in[p]  = act[2*p];
                next_s.dt_cnt[p] = 8'h00;
            end else begin
                // Odd override bits replace the generator
                in_now  = s.src_override ? s.override[2*p] : gen[2*p];
                changed = in_now != s.dt_in[p];
                // Counted on every clock, never on prescaled ticks
                if (changed) begin
                    next_s.dt_cnt[p] = s.deadtime;
                end else if (s.dt_cnt[p] != 8'h00) begin
                    next_s.dt_cnt[p] = s.dt_cnt[p] - 8'h01;
                end
                next_s.dt_in[p] = in_now;
                // Both outputs inactive through the dead-time
                hold = changed ? (s.deadtime != 8'h00)
                               : (s.dt_cnt[p] > 8'h01);
                // Top from the dead-time input, bottom derived
                act[2*p] = in_now & ~hold;
                // Even override bit gates the complement
                // Even bit change inserts no gap yet waits for it
                act[2*p+1] = (s.src_override ? s.override[2*p+1] : 1'b1)
                           & ~in_now & ~hold;
            end
        end

        for (int i = 0; i < 6; i++) begin
            // Mapping bits select outputs per bank
            // All mapping bits set cover every output
            if ((next_s.off_x & s.disable_bank_mapping[i]) |
                (next_s.off_y & map_y(s.disable_bank_mapping, i))) begin
                act[i] = 1'b0;
            end
            // Odd outputs use top polarity, even ones bottom
            next_s.pin[i] = drive_level(act[i],
                                        (i % 2 == 0) ? s.top_neg
                                                     : s.bot_neg);
        end

        // Override drives the pins without the module enable
        drive       = s.enable | s.override[`OVR_ENABLE];
        next_s.oe_n = {6{~drive}};

        next_s.rdata = 8'h00;
        if (bus_req.rd) begin
            case (bus_req.addr)
                `ADDR_CONFIG: begin
                    next_s.rdata = {5'h00, s.bot_neg, s.top_neg, s.channel_independence_option};
                end
                `ADDR_DEADTIME: begin
                    next_s.rdata = s.deadtime;
                end
                `ADDR_DISABLE_BANK_MAPPING: begin
                    next_s.rdata = s.disable_bank_mapping;
                end
                `ADDR_OVERRIDE: begin
                    next_s.rdata = s.override;
                end
                `ADDR_CONTROL: begin
                    next_s.rdata = {5'h00, s.dis_y, s.dis_x, s.enable};
                end
                `ADDR_FAULT_CTRL: begin
                    next_s.rdata = {4'h0, s.fint4, s.fint1,
                                    s.fmode4, s.fmode1};
                end
                `ADDR_FAULT_STAT: begin
                    next_s.rdata = {4'h0, s.sync2[1], s.flag4,
                                    s.sync2[0], s.flag1};
                end
                `ADDR_OUT_STATUS: begin
                    next_s.rdata = {s.off_y, s.off_x, s.pin};
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end
        if (wr_cfg && s.cfg_written) begin
            next_s.channel_independence_option = s.channel_independence_option;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s          <= '0;
            s.deadtime <= `DEADTIME_RESET;
            s.disable_bank_mapping   <= `DISABLE_BANK_MAPPING_RESET;
            s.oe_n     <= 6'h3f;
        end else begin
            s <= next_s;
        end
    end

    assign rdata     = s.rdata;
    assign pwm_pin   = s.pin;
    assign pwm_oe_n  = s.oe_n;
    assign fault_irq = s.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_config_once;
        s.cfg_written |=> $stable({s.channel_independence_option, s.top_neg, s.bot_neg});
    endproperty
    a_config_once: assert property (p_config_once)
        else $error("configuration changed after first write");

    property p_deadtime_once;
        s.dt_written |=> $stable(s.deadtime);
    endproperty
    a_deadtime_once: assert property (p_deadtime_once)
        else $error("dead-time changed after first write");

    property p_pair_exclusive;
        !s.channel_independence_option |-> ((pin_act[0] & pin_act[1]) |
                      (pin_act[2] & pin_act[3]) |
                      (pin_act[4] & pin_act[5])) == 1'b0;
    endproperty
    a_pair_exclusive: assert property (p_pair_exclusive)
        else $error("both outputs of a pair active");

    property p_gap_on_change;
        !s.channel_independence_option && s.deadtime != 8'h00 && $changed(s.dt_in[0])
            |-> !pin_act[0] && !pin_act[1];
    endproperty
    a_gap_on_change: assert property (p_gap_on_change)
        else $error("pair 1 active at a dead-time input change");

    property p_all_mapped;
        s.disable_bank_mapping == 8'hff && (s.off_x || s.off_y) |-> pin_act == 6'h00;
    endproperty
    a_all_mapped: assert property (p_all_mapped)
        else $error("output active with full mapping disabled");

    property p_bank_x_fault;
        s.fmode1 && s.sync2[0] |=> s.off_x;
    endproperty
    a_bank_x_fault: assert property (p_bank_x_fault)
        else $error("fault 1 did not disable bank X");

    property p_fault4_held;
        s.sync2[1] |=> s.off_y ##1 (s.off_y || !$past(s.sync2[1]));
    endproperty
    a_fault4_held: assert property (p_fault4_held)
        else $error("bank Y released while fault 4 input high");

    property p_override_drives;
        s.override[`OVR_ENABLE] |=> s.oe_n == 6'h00;
    endproperty
    a_override_drives: assert property (p_override_drives)
        else $error("override set but pins not driven");

    property p_override_exit;
        s.src_override && !s.override[`OVR_ENABLE] && !cycle_start &&
            s.enable |=> s.src_override;
    endproperty
    a_override_exit: assert property (p_override_exit)
        else $error("generator took pins before period start");

    property p_fault_irq;
        s.sync2[0] && !s.f_prev[0] && s.fint1 |=> s.irq[0];
    endproperty
    a_fault_irq: assert property (p_fault_irq)
        else $error("fault 1 edge raised no request");

    property p_map_bit;
        s.off_x && s.disable_bank_mapping[0] |-> !pin_act[0];
    endproperty
    a_map_bit: assert property (p_map_bit)
        else $error("mapped output 1 active while bank X off");

    property p_soft_disable;
        s.dis_x && s.disable_bank_mapping[1] |=> !pin_act[1];
    endproperty
    a_soft_disable: assert property (p_soft_disable)
        else $error("software disable left mapped output 2 active");

    property p_channel_independence_option_override;
        s.channel_independence_option && s.src_override && !s.dis_x && !s.dis_y &&
            !s.flag1 && !s.flag4 && !s.sync2[0] && !s.sync2[1]
            |=> pin_act[1:0] == $past(s.override[1:0]);
    endproperty
    a_channel_independence_option_override: assert property (p_channel_independence_option_override)
        else $error("independent output ignored its override bit");

    property p_bottom_gated;
        !s.channel_independence_option && s.src_override && !s.override[1] |=> !pin_act[1];
    endproperty
    a_bottom_gated: assert property (p_bottom_gated)
        else $error("bottom output active with its override bit clear");

endmodule

// ==== bench/gate_driver_model.sv ====
/*
 * Behavioural gate drivers of a three-phase inverter bridge.
 * Assumes outputs 1/2, 3/4 and 5/6 drive the top/bottom switches of one
 * leg, and that the polarity options match those written to the stage.
 */
module gate_driver_model
    import pwm_stage_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [5:0] pwm_pin,
    input  wire logic [5:0] pwm_oe_n,
    input  wire logic       top_neg,
    input  wire logic       bot_neg,
    output logic [5:0]      gate_on,
    output int              shoot_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // Polarity decode; an undriven pin is pulled to switch off
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            gate_on[i] = !pwm_oe_n[i]
                && (pwm_pin[i] ^ (i[0] ? bot_neg : top_neg));
        end
    end

    // Counts shoot-through; starts at zero as a two-state int
    always @(posedge ref_clk) begin
        for (int p = 0; p < 3; p++) begin
            if (gate_on[2*p] && gate_on[2*p+1]) begin
                shoot_count++;
            end
        end
    end
endmodule

// ==== bench/tb_motor_pwm_output_stage.sv ====
/*
 * Self-checking bench of the motor PWM output stage.
 * Assumes the gate driver model and the register map header.
 */
`include "pwm_stage_regs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end end

module tb_motor_pwm_output_stage
    import pwm_stage_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DT = 3;
    logic        ref_clk     = 1'b0;
    logic        rst_n       = 1'b0;
    bus_req_type bus_req     = '0;
    logic [5:0]  gen_out     = 6'h00;
    logic        cycle_start = 1'b0;
    logic        fault1_pin  = 1'b0;
    logic        fault4_pin  = 1'b0;
    logic        top_neg     = 1'b0;
    logic [7:0]  rdata;
    logic [5:0]  pwm_pin;
    logic [5:0]  pwm_oe_n;
    logic [1:0]  fault_irq;
    logic [5:0]  gate_on;
    logic [7:0]  rd_val;
    int          shoot_count;
    int          n;
    int          n_errors    = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    motor_pwm_output_stage i_dut (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .bus_req     (bus_req),
        .rdata       (rdata),
        .gen_out     (gen_out),
        .cycle_start (cycle_start),
        .fault1_pin  (fault1_pin),
        .fault4_pin  (fault4_pin),
        .pwm_pin     (pwm_pin),
        .pwm_oe_n    (pwm_oe_n),
        .fault_irq   (fault_irq)
    );

    gate_driver_model i_model (
        .ref_clk     (ref_clk),
        .pwm_pin     (pwm_pin),
        .pwm_oe_n    (pwm_oe_n),
        .top_neg     (top_neg),
        .bot_neg     (1'b0),
        .gate_on     (gate_on),
        .shoot_count (shoot_count)
    );

    always #4 ref_clk = ~ref_clk;

    // Cuts a hung run short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize;
        $display("Errors %0d in %0d comparisons", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic release_reset;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask

    // Period start, then time for dead-time to pass
    task automatic pins_on;
        @(posedge ref_clk);
        cycle_start <= 1'b1;
        @(posedge ref_clk);
        cycle_start <= 1'b0;
        tick(DT + 4);
    endtask

    task automatic set_faults(input logic f1, input logic f4);
        @(posedge ref_clk);
        fault1_pin <= f1;
        fault4_pin <= f4;
        tick(4);
    endtask

    // Edges until pin b reaches v; the pair stays off inside the gap
    task automatic wait_pin(input int b, input logic v, output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
            if (k >= 2 && k <= DT) `CHK(gate_on[b] | gate_on[b ^ 1], 1'b0)
        end while (pwm_pin[b] !== v && k < 50);
    endtask

    initial begin
        release_reset();
        rd(`ADDR_DEADTIME, rd_val);
        `CHK(rd_val, `DEADTIME_RESET)
        rd(`ADDR_DISABLE_BANK_MAPPING, rd_val);
        `CHK(rd_val, `DISABLE_BANK_MAPPING_RESET)
        rd(4'h8, rd_val);
        `CHK(rd_val, 8'h00)
        wr(`ADDR_CONFIG, 8'h00);
        wr(`ADDR_CONFIG, 8'h06);
        rd(`ADDR_CONFIG, rd_val);
        `CHK(rd_val, 8'h00)
        wr(`ADDR_DEADTIME, 8'(DT));
        wr(`ADDR_DEADTIME, 8'h07);
        rd(`ADDR_DEADTIME, rd_val);
        `CHK(rd_val, 8'(DT))
        wr(`ADDR_CONTROL, 8'h01);
        tick(DT + 4);
        `CHK(pwm_pin, 6'h2a)
        `CHK(pwm_oe_n, 6'h00)
        @(posedge ref_clk);
        gen_out <= 6'h01;
        wait_pin(0, 1'b1, n);
        `CHK(n, DT + 1)
        `CHK(pwm_pin, 6'h29)
        @(posedge ref_clk);
        gen_out <= 6'h00;
        wait_pin(1, 1'b1, n);
        `CHK(n, DT + 1)
        @(posedge ref_clk);
        gen_out <= 6'h2a;
        tick(4);
        `CHK(pwm_pin, 6'h2a)
        // Override entered with its bits clear, module disabled
        wr(`ADDR_CONTROL, 8'h00);
        wr(`ADDR_OVERRIDE, 8'h80);
        tick(DT + 4);
        `CHK(pwm_pin, 6'h00)
        `CHK(pwm_oe_n, 6'h00)
        wr(`ADDR_OVERRIDE, 8'h81);
        wait_pin(0, 1'b1, n);
        `CHK(n >= DT && n <= DT + 2, 1'b1)
        wr(`ADDR_OVERRIDE, 8'h83);
        tick(3);
        `CHK(pwm_pin, 6'h01)
        wr(`ADDR_OVERRIDE, 8'h82);
        wait_pin(1, 1'b1, n);
        `CHK(n >= DT && n <= DT + 2, 1'b1)
        `CHK(pwm_pin, 6'h02)
        wr(`ADDR_OVERRIDE, 8'h80);
        wr(`ADDR_CONTROL, 8'h01);
        @(posedge ref_clk);
        gen_out <= 6'h15;
        wr(`ADDR_OVERRIDE, 8'h00);
        tick(DT + 4);
        `CHK(pwm_pin, 6'h00)
        pins_on();
        `CHK(pwm_pin, 6'h15)
        // Automatic fault 1
        wr(`ADDR_FAULT_CTRL, 8'h0f);
        set_faults(1'b1, 1'b0);
        `CHK(pwm_pin, 6'h00)
        `CHK(fault_irq, 2'b01)
        rd(`ADDR_OUT_STATUS, rd_val);
        `CHK(rd_val, 8'h40)
        set_faults(1'b0, 1'b0);
        `CHK(pwm_pin, 6'h00)
        pins_on();
        `CHK(pwm_pin, 6'h15)
        wr(`ADDR_FAULT_STAT, 8'h01);
        tick(2);
        `CHK(fault_irq, 2'b00)
        // Manual fault 4, acknowledged while the pin is still high
        wr(`ADDR_FAULT_CTRL, 8'h08);
        set_faults(1'b0, 1'b1);
        `CHK(pwm_pin, 6'h00)
        `CHK(fault_irq, 2'b10)
        wr(`ADDR_FAULT_STAT, 8'h04);
        pins_on();
        `CHK(pwm_pin, 6'h00)
        set_faults(1'b0, 1'b0);
        pins_on();
        `CHK(pwm_pin, 6'h15)
        `CHK(fault_irq, 2'b00)
        // Manual fault 1 clears with its pin high
        wr(`ADDR_FAULT_CTRL, 8'h00);
        set_faults(1'b1, 1'b0);
        `CHK(pwm_pin, 6'h00)
        wr(`ADDR_FAULT_STAT, 8'h01);
        pins_on();
        `CHK(pwm_pin, 6'h15)
        set_faults(1'b0, 1'b0);
        wr(`ADDR_CONTROL, 8'h05);
        tick(2);
        `CHK(pwm_pin, 6'h00)
        wr(`ADDR_CONTROL, 8'h01);
        tick(DT + 4);
        `CHK(pwm_pin, 6'h00)
        pins_on();
        `CHK(pwm_pin, 6'h15)
        `CHK(shoot_count, 0)
        // Independent channels, negative top polarity, partial mapping
        @(posedge ref_clk);
        rst_n <= 1'b0;
        release_reset();
        wr(`ADDR_DISABLE_BANK_MAPPING, 8'h07);
        wr(`ADDR_CONFIG, 8'h03);
        top_neg <= 1'b1;
        wr(`ADDR_CONTROL, 8'h01);
        @(posedge ref_clk);
        gen_out <= 6'h3f;
        tick(3);
        `CHK(pwm_pin, 6'h2a)
        wr(`ADDR_CONTROL, 8'h03);
        tick(2);
        `CHK(pwm_pin, 6'h2d)
        wr(`ADDR_CONTROL, 8'h01);
        pins_on();
        wr(`ADDR_OVERRIDE, 8'h83);
        tick(3);
        `CHK(pwm_pin, 6'h16)
        summarize();
    end
endmodule
